// ===== rtl/swc_map.svh
// Constants for the scalar write-through cache
`ifndef SWC_MAP_SVH
`define SWC_MAP_SVH
`define SWC_ADDR_W  32
`define SWC_IDX_W   6
`define SWC_TAG_W   26
`define SWC_SETS    64
`define SWC_WAYS    2
`define SWC_DATA_W  64
`define SWC_QDEPTH  8
`define SWC_PROC_W  5
`define SWC_CLK_NS  10
`define SWC_HIT_LAT_CP 7
`define SWC_HIT_STAGES (`SWC_HIT_LAT_CP - 1)
`endif

// ===== rtl/swc_pkg.sv
// Types for the scalar write-through cache
`default_nettype none
package swc_pkg;
  typedef enum logic [2:0] {
    SWC_OP_FETCH,
    SWC_OP_SREAD,
    SWC_OP_SWRITE,
    SWC_OP_VREAD,
    SWC_OP_VWRITE,
    SWC_OP_EXCHANGE,
    SWC_OP_FLUSH
  } swc_op_e;
endpackage
`default_nettype wire

// ===== rtl/swc_cache.sv
// Scalar write-through cache, 64 sets of two one-word lines
// Contract
// - Hold 128 words as 64 sets of two one-word lines.
// - Replace the least recently used line of the set, per set.
// - Only scalar A and S references use or fill the cache.
// - A vector write invalidates lines whose tag matches its address.
// - Exchange or flush invalidates every line.
// - Fetches change nothing in the cache but still request memory.
// - Scalar writes go to memory and update a hit or allocated word.
// - Each scalar reference issues exactly one memory request.
// - A read hit still requests memory; that return is discarded unless the hit line awaits data, then it goes to the CPU.
// - Hit data usable by a dependent issue 7 clock periods later.
// - Only scalar read and write misses allocate lines.
// - Read miss return is written to cache and forwarded to CPU.
// - Monitor-mode command invalidates the numbered processor's whole cache.
// - Hit needs valid tag and match; otherwise choose a line to allocate.
// - A requested line is never chosen for allocation.
// - Miss without allocatable line requests memory, cache untouched.
// - Return updates word only if return-to-cache set and still requested.
// - Invalidation clears only the tag valid bit.
`timescale 1ns/1ps
`default_nettype none
`include "swc_map.svh"
module swc_cache
  import swc_pkg::*;
#(
  parameter int DATA_W = `SWC_DATA_W,
  parameter int QDEPTH = `SWC_QDEPTH
) (
  input  wire logic                   clk_sys_i,      // System clock
  input  wire logic                   rst_n_i,        // Async reset, active low
  input  wire logic                   clk_en_i,       // Freezes all state when low
  input  wire logic [`SWC_PROC_W-1:0] proc_num_i,     // This processor's number
  input  wire logic                   req_valid_i,    // CPU reference valid
  output logic                        req_ready_o,    // Reference taken when high
  input  wire swc_op_e                req_op_i,       // Reference kind
  input  wire logic [`SWC_ADDR_W-1:0] req_addr_i,     // Word address
  input  wire logic [DATA_W-1:0]      req_wdata_i,    // Write data
  input  wire logic                   mem_ready_i,    // Memory port accepts request
  output logic                        mem_req_o,      // Memory request strobe
  output logic                        mem_we_o,       // Memory request is a write
  output logic [`SWC_ADDR_W-1:0]      mem_addr_o,     // Memory request address
  output logic [DATA_W-1:0]           mem_wdata_o,    // Memory write data
  input  wire logic                   mem_ret_valid_i, // Scalar read return strobe
  input  wire logic [DATA_W-1:0]      mem_ret_data_i, // Scalar read return data
  output logic                        cpu_hit_valid_o, // Hit data ready pulse
  output logic [DATA_W-1:0]           cpu_hit_data_o, // Hit data
  output logic                        cpu_ret_valid_o, // Miss return to register
  output logic [DATA_W-1:0]           cpu_ret_data_o, // Miss return data
  input  wire logic                   ivrc_issue_i,   // This CPU issues remote invalidate
  input  wire logic                   ivrc_monitor_i, // Issuer is in monitor mode
  input  wire logic [`SWC_PROC_W-1:0] ivrc_target_i,  // Target processor number
  output logic                        ivrc_out_o,     // Broadcast invalidate pulse
  output logic [`SWC_PROC_W-1:0]      ivrc_out_num_o, // Broadcast target number
  input  wire logic                   ivrc_in_i,      // Incoming invalidate pulse
  input  wire logic [`SWC_PROC_W-1:0] ivrc_in_num_i   // Incoming target number
);

  localparam int QW = $clog2(QDEPTH);
  localparam int HS = `SWC_HIT_STAGES;

  // ----------------------------------------
  // Line storage
  // ----------------------------------------
  logic [`SWC_TAG_W-1:0] tag_q [`SWC_WAYS][`SWC_SETS], tag_d [`SWC_WAYS][`SWC_SETS];
  logic [DATA_W-1:0]     dat_q [`SWC_WAYS][`SWC_SETS], dat_d [`SWC_WAYS][`SWC_SETS];
  logic [`SWC_SETS-1:0]  tv_q  [`SWC_WAYS], tv_d [`SWC_WAYS];
  logic [`SWC_SETS-1:0]  rq_q  [`SWC_WAYS], rq_d [`SWC_WAYS];
  logic [`SWC_SETS-1:0]  lru_q, lru_d; // Bit gives the way to replace next

  // Port queue: cache address plus return-to-cache and return-to-register
  logic [`SWC_IDX_W-1:0] pq_set_q [QDEPTH], pq_set_d [QDEPTH];
  logic                  pq_way_q [QDEPTH], pq_way_d [QDEPTH];
  logic                  pq_rtc_q [QDEPTH], pq_rtc_d [QDEPTH];
  logic                  pq_rtr_q [QDEPTH], pq_rtr_d [QDEPTH];
  logic [QW:0]           wp_q, wp_d, rp_q, rp_d;

  logic [HS-1:0]         hv_q, hv_d;
  logic [DATA_W-1:0]     hd_q [HS], hd_d [HS];
  logic                  rv_q, rv_d;
  logic [DATA_W-1:0]     rd_q, rd_d;
  logic                  io_q, io_d;
  logic [`SWC_PROC_W-1:0] in_q, in_d;

  logic [`SWC_IDX_W-1:0] set_w;
  logic [`SWC_TAG_W-1:0] tag_w;
  logic [1:0]            hit_w;
  logic                  pq_full, take, is_scalar;

  assign set_w     = req_addr_i[`SWC_IDX_W-1:0];
  assign tag_w     = req_addr_i[`SWC_ADDR_W-1:`SWC_IDX_W];
  assign is_scalar = (req_op_i == SWC_OP_SREAD) || (req_op_i == SWC_OP_SWRITE);
  assign pq_full   = (wp_q[QW-1:0] == rp_q[QW-1:0]) && (wp_q[QW] != rp_q[QW]);

  // Scalar reads wait for queue room so no return loses its entry
  assign req_ready_o = clk_en_i && (req_op_i == SWC_OP_FLUSH ||
                       (mem_ready_i && !(req_op_i == SWC_OP_SREAD && pq_full)));
  assign take        = req_valid_i && req_ready_o;

  // ----------------------------------------
  // Memory request path
  // ----------------------------------------
  assign mem_req_o   = take && (req_op_i != SWC_OP_FLUSH);
  assign mem_we_o    = req_op_i == SWC_OP_SWRITE || req_op_i == SWC_OP_VWRITE;
  assign mem_addr_o  = req_addr_i;
  assign mem_wdata_o = req_wdata_i;

  assign hit_w[0] = tv_q[0][set_w] && (tag_q[0][set_w] == tag_w);
  assign hit_w[1] = tv_q[1][set_w] && (tag_q[1][set_w] == tag_w);

  // ----------------------------------------
  // Next-state of cache, queue and outputs
  // ----------------------------------------
  always_comb
  begin
    logic [QW-1:0]         ri;
    logic [`SWC_IDX_W-1:0] rs;
    logic                  rw, aw, can_alloc, hw;
    ri = rp_q[QW-1:0];
    rw = pq_way_q[ri];
    rs = pq_set_q[ri];
    aw = 1'b0;
    can_alloc = 1'b0;
    hw = hit_w[1];
    tag_d = tag_q;
    dat_d = dat_q;
    tv_d  = tv_q;
    rq_d  = rq_q;
    lru_d = lru_q;
    pq_set_d = pq_set_q;
    pq_way_d = pq_way_q;
    pq_rtc_d = pq_rtc_q;
    pq_rtr_d = pq_rtr_q;
    wp_d = wp_q;
    rp_d = rp_q;
    hv_d = {hv_q[HS-2:0], 1'b0};
    for (int s = HS-1; s > 0; s--)
      hd_d[s] = hd_q[s-1];
    hd_d[0] = hd_q[0];
    rv_d = 1'b0;
    rd_d = rd_q;
    io_d = ivrc_issue_i && ivrc_monitor_i;
    in_d = ivrc_issue_i ? ivrc_target_i : in_q;

    // Returns first, so a request in the same cycle overrides the line
    if (mem_ret_valid_i && (rp_q != wp_q))
    begin
      if (pq_rtc_q[ri] && rq_q[rw][rs])
      begin
        dat_d[rw][rs] = mem_ret_data_i;
        rq_d[rw][rs]  = 1'b0;
      end
      if (pq_rtr_q[ri])
      begin
        rv_d = 1'b1;
        rd_d = mem_ret_data_i;
      end
      rp_d = rp_q + 1'b1;
    end

    // Pick the LRU way unless it awaits data
    if (!rq_q[lru_q[set_w]][set_w])
    begin
      aw = lru_q[set_w];
      can_alloc = 1'b1;
    end
    else if (!rq_q[!lru_q[set_w]][set_w])
    begin
      aw = !lru_q[set_w];
      can_alloc = 1'b1;
    end

    if (take)
    begin
      case (req_op_i)
        SWC_OP_SREAD, SWC_OP_SWRITE:
        begin
          if (|hit_w)
          begin
            lru_d[set_w] = !hw;
            if (req_op_i == SWC_OP_SWRITE)
            begin
              dat_d[hw][set_w] = req_wdata_i;
              rq_d[hw][set_w]  = 1'b0;
            end
            else if (!rq_q[hw][set_w])
            begin
              hv_d[0] = 1'b1;
              hd_d[0] = dat_q[hw][set_w];
            end
          end
          else if (can_alloc && is_scalar)
          begin
            tag_d[aw][set_w] = tag_w;
            tv_d[aw][set_w]  = 1'b1;
            lru_d[set_w]     = !aw;
            if (req_op_i == SWC_OP_SWRITE)
            begin
              dat_d[aw][set_w] = req_wdata_i;
              rq_d[aw][set_w]  = 1'b0;
            end
            else
              rq_d[aw][set_w] = 1'b1;
          end
          if (req_op_i == SWC_OP_SREAD)
          begin
            // Hit: redundant request, its return is dropped unless the hit line awaits data
            pq_set_d[wp_q[QW-1:0]] = set_w;
            pq_way_d[wp_q[QW-1:0]] = aw;
            pq_rtc_d[wp_q[QW-1:0]] = !(|hit_w) && can_alloc;
            pq_rtr_d[wp_q[QW-1:0]] = !(|hit_w) || rq_q[hw][set_w];
            wp_d = wp_q + 1'b1;
          end
        end
        SWC_OP_VWRITE:
        begin
          for (int w = 0; w < `SWC_WAYS; w++)
            if (hit_w[w])
              tv_d[w][set_w] = 1'b0;
        end
        SWC_OP_EXCHANGE, SWC_OP_FLUSH:
        begin
          tv_d = '{default: '0};
        end
        // Fetch and vector read leave the cache alone
        default: ;
      endcase
    end

    if (ivrc_in_i && ivrc_in_num_i == proc_num_i)
      tv_d = '{default: '0};
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      tv_q  <= '{default: '0};
      rq_q  <= '{default: '0};
      lru_q <= '0;
      wp_q  <= '0;
      rp_q  <= '0;
      hv_q  <= '0;
      rv_q  <= 1'b0;
      rd_q  <= '0;
      io_q  <= 1'b0;
      in_q  <= '0;
      hd_q  <= '{default: '0};
    end
    else if (clk_en_i)
    begin
      tv_q  <= tv_d;
      rq_q  <= rq_d;
      lru_q <= lru_d;
      wp_q  <= wp_d;
      rp_q  <= rp_d;
      hv_q  <= hv_d;
      hd_q  <= hd_d;
      rv_q  <= rv_d;
      rd_q  <= rd_d;
      io_q  <= io_d;
      in_q  <= in_d;
    end
  end

  // Storage arrays carry no reset; valid bits and queue pointers guard them
  always_ff @(posedge clk_sys_i)
  begin
    if (clk_en_i)
    begin
      tag_q    <= tag_d;
      dat_q    <= dat_d;
      pq_set_q <= pq_set_d;
      pq_way_q <= pq_way_d;
      pq_rtc_q <= pq_rtc_d;
      pq_rtr_q <= pq_rtr_d;
    end
  end

  assign cpu_hit_valid_o = hv_q[HS-1];
  assign cpu_hit_data_o  = hd_q[HS-1];
  assign cpu_ret_valid_o = rv_q;
  assign cpu_ret_data_o  = rd_q;
  assign ivrc_out_o      = io_q;
  assign ivrc_out_num_o  = in_q;

endmodule // swc_cache
`default_nettype wire

// ===== bench/swc_cache_monitor.sv
// Port checker for the scalar write-through cache
`timescale 1ns/1ps
`default_nettype none
module swc_cache_monitor
  import swc_pkg::*;
(
  input wire logic    clk_sys_i,       // Clock
  input wire logic    rst_n_i,         // Reset
  input wire logic    clk_en_i,        // Enable
  input wire logic    req_valid_i,     // Valid
  input wire logic    req_ready_o,     // Ready
  input wire swc_op_e req_op_i,        // Kind
  input wire logic    mem_req_o,       // Request
  input wire logic    mem_we_o,        // Write
  input wire logic    mem_ret_valid_i, // Return
  input wire logic    cpu_ret_valid_o, // Forward
  input wire logic    cpu_hit_valid_o, // Hit
  input wire logic    ivrc_issue_i,    // Command
  input wire logic    ivrc_monitor_i,  // Privilege
  input wire logic    ivrc_out_o       // Broadcast
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  logic tk;
  logic tk_sr;
  logic cmd;
  assign tk = req_valid_i && req_ready_o;
  assign tk_sr = tk && req_op_i == SWC_OP_SREAD;
  assign cmd = ivrc_issue_i && ivrc_monitor_i && clk_en_i;
  sequence s_cmd; cmd; endsequence
  sequence s_bcast; ivrc_out_o; endsequence
  property p_req; tk && req_op_i != SWC_OP_FLUSH |-> mem_req_o; endproperty
  property p_idle; !tk |-> !mem_req_o; endproperty
  property p_flush; clk_en_i && req_op_i == SWC_OP_FLUSH |-> req_ready_o && !mem_req_o; endproperty
  property p_we; mem_req_o |-> mem_we_o == (req_op_i inside {SWC_OP_SWRITE, SWC_OP_VWRITE}); endproperty
  property p_ret; cpu_ret_valid_o |-> $past(mem_ret_valid_i); endproperty
  property p_hit; cpu_hit_valid_o |-> $past(tk_sr, 6); endproperty
  property p_bcast; s_cmd |=> s_bcast; endproperty
  property p_bc_only; ivrc_out_o |-> $past(cmd); endproperty
  a_req: assert property (p_req) else $error("memory request missing");
  a_idle: assert property (p_idle) else $error("memory request without reference");
  a_flush: assert property (p_flush) else $error("flush refused or requested");
  a_we: assert property (p_we) else $error("write flag wrong");
  a_ret: assert property (p_ret) else $error("forward without return");
  a_hit: assert property (p_hit) else $error("hit pulse mistimed");
  a_bcast: assert property (p_bcast) else $error("invalidate not sent");
  a_bc_only: assert property (p_bc_only) else $error("invalidate sent unasked");
endmodule // swc_cache_monitor
bind swc_cache swc_cache_monitor i_swc_cache_monitor (
  .clk_sys_i, .rst_n_i, .clk_en_i, .req_valid_i, .req_ready_o, .req_op_i, .mem_req_o,
  .mem_we_o, .mem_ret_valid_i, .cpu_ret_valid_o, .cpu_hit_valid_o, .ivrc_issue_i,
  .ivrc_monitor_i, .ivrc_out_o);
`default_nettype wire

// ===== bench/swc_mem_model.sv
// Central memory port model answering scalar reads in order
`timescale 1ns/1ps
`default_nettype none
module swc_mem_model #(
  parameter int LAT = 3
) (
  input  wire logic        clk_i,   // Clock
  input  wire logic        rst_n_i, // Reset
  input  wire logic        stall_i, // Refuse
  input  wire logic        req_i,   // Request
  input  wire logic        we_i,    // Write
  input  wire logic        sread_i, // Scalar read
  input  wire logic [31:0] addr_i,  // Address
  output logic             ready_o, // Accepts
  output logic             ret_o,   // Strobe
  output logic [63:0]      data_o   // Data
);
  logic [31:0] q[$];
  int          cnt;
  assign ready_o = !stall_i;
  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      q.delete();
      cnt = 0;
      ret_o <= 1'b0;
      data_o <= '0;
    end
    else
    begin
      ret_o <= 1'b0;
      data_o <= ~data_o; // Stale data inverts each cycle, matching the last return every other cycle
      if (q.size() != 0 && cnt >= LAT)
      begin
        ret_o <= 1'b1;
        data_o <= {32'h5A5A0000, q.pop_front()};
        cnt = 0;
      end
      else if (q.size() != 0)
        cnt++;
      if (req_i && ready_o && !we_i && sread_i)
        q.push_back(addr_i);
    end
  end
endmodule // swc_mem_model
`default_nettype wire

// ===== bench/swc_cache_tb_top.sv
// Self-checking testbench for the scalar write-through cache
`timescale 1ns/1ps
`default_nettype none
module swc_cache_tb_top
  import swc_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        vld = 1'b0;
  logic        stall = 1'b0;
  logic        iss = 1'b0;
  logic        mon = 1'b0;
  logic        inv = 1'b0;
  swc_op_e     op = SWC_OP_FETCH;
  logic [31:0] adr = '0;
  logic [63:0] wd = '0;
  logic [4:0]  inv_num = '0;
  logic        rdy, mrdy, mreq, mwe, rv, hv, cv, bo;
  logic [31:0] madr;
  logic [63:0] rd, hd, cd, mwd;
  logic [4:0]  bn;
  int          error_cnt = 0;
  int          comparisons = 0;
  always #5 clk = ~clk;
  swc_cache i_swc_cache (
    .clk_sys_i(clk), .rst_n_i(rst_n), .clk_en_i(1'b1), .proc_num_i(5'h03),
    .req_valid_i(vld), .req_ready_o(rdy), .req_op_i(op), .req_addr_i(adr),
    .req_wdata_i(wd), .mem_ready_i(mrdy), .mem_req_o(mreq), .mem_we_o(mwe),
    .mem_addr_o(madr), .mem_wdata_o(mwd), .mem_ret_valid_i(rv), .mem_ret_data_i(rd),
    .cpu_hit_valid_o(hv), .cpu_hit_data_o(hd), .cpu_ret_valid_o(cv), .cpu_ret_data_o(cd),
    .ivrc_issue_i(iss), .ivrc_monitor_i(mon), .ivrc_target_i(5'h09), .ivrc_out_o(bo),
    .ivrc_out_num_o(bn), .ivrc_in_i(inv), .ivrc_in_num_i(inv_num));
  swc_mem_model i_swc_mem_model (
    .clk_i(clk), .rst_n_i(rst_n), .stall_i(stall), .req_i(mreq), .we_i(mwe),
    .sread_i(op == SWC_OP_SREAD), .addr_i(madr), .ready_o(mrdy), .ret_o(rv), .data_o(rd));
  function automatic logic [63:0] mw(input logic [31:0] a);
    return {32'h5A5A0000, a};
  endfunction
  task automatic final_report();
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic step();
    @(posedge clk);
    #1;
  endtask
  task automatic issue(input swc_op_e o, input logic [31:0] a, input logic [63:0] d);
    step();
    op = o;
    adr = a;
    wd = d;
    vld = 1'b1;
    #1;
    for (int n = 0; rdy !== 1'b1; n++)
    begin
      if (n > 40)
      begin
        error_cnt++;
        final_report();
      end
      step();
    end
    chk(mreq, o != SWC_OP_FLUSH);
    chk(madr, a);
    if (o == SWC_OP_SWRITE)
      chk(mwd, d);
    step();
    vld = 1'b0;
  endtask
  // Window covers the hit pulse and any return of the same read
  task automatic rd_check(input logic [31:0] a, input logic [63:0] exp, input logic hit);
    logic gh;
    logic gr;
    int   th;
    gh = 1'b0;
    gr = 1'b0;
    th = -1;
    issue(SWC_OP_SREAD, a, '0);
    for (int n = 0; n < 12; n++)
    begin
      if (hv === 1'b1 && th < 0)
        th = n;
      gh |= hv === 1'b1;
      gr |= cv === 1'b1;
      step();
    end
    chk(gh, hit);
    chk(gr, !hit);
    chk(hit ? hd : cd, exp);
    chk(th, hit ? 5 : -1);
  endtask
  // Three reads in flight to one set: third finds both ways requested
  task automatic sc_pending();
    logic [31:0] base;
    int          nr;
    for (int k = 0; k < 2; k++)
    begin
      base = k ? 32'h0E : 32'h07;
      nr = 0;
      inv_num = 5'h03;
      issue(SWC_OP_SREAD, base + 32'h100, '0);
      inv = (k == 1);
      issue(SWC_OP_SREAD, base + 32'h200, '0);
      inv = 1'b0;
      issue(SWC_OP_SREAD, base + 32'h300, '0);
      repeat (16)
      begin
        nr += (cv === 1'b1);
        step();
      end
      chk(nr, 3);
      chk(cd, mw(base + 32'h300));
      rd_check(base + 32'h100, mw(base + 32'h100), k == 0);
      rd_check(base + 32'h200, mw(base + 32'h200), k == 0);
      rd_check(base + 32'h300, mw(base + 32'h300), 1'b0);
    end
    issue(SWC_OP_SREAD, 32'h0B, '0);
    issue(SWC_OP_SWRITE, 32'h0B, 64'h1122334455667788);
    repeat (12) step();
    chk(cd, mw(32'h0B));
    rd_check(32'h0B, 64'h1122334455667788, 1'b1);
  endtask
  task automatic sc_basic();
    rd_check(32'h10, mw(32'h10), 1'b0);
    rd_check(32'h10, mw(32'h10), 1'b1);
    rd_check(32'h50, mw(32'h50), 1'b0);
    rd_check(32'h10, mw(32'h10), 1'b1);
    issue(SWC_OP_SWRITE, 32'h10, 64'h0123456789ABCDEF);
    rd_check(32'h10, 64'h0123456789ABCDEF, 1'b1);
    issue(SWC_OP_SWRITE, 32'h20, 64'hFEDCBA9876543210);
    rd_check(32'h20, 64'hFEDCBA9876543210, 1'b1);
  endtask
  task automatic sc_lru();
    rd_check(32'h105, mw(32'h105), 1'b0);
    rd_check(32'h205, mw(32'h205), 1'b0);
    rd_check(32'h105, mw(32'h105), 1'b1);
    rd_check(32'h305, mw(32'h305), 1'b0);
    rd_check(32'h105, mw(32'h105), 1'b1);
    rd_check(32'h205, mw(32'h205), 1'b0);
  endtask
  task automatic sc_bypass();
    issue(SWC_OP_VWRITE, 32'h20, '0);
    rd_check(32'h20, mw(32'h20), 1'b0);
    issue(SWC_OP_FETCH, 32'h30, '0);
    issue(SWC_OP_VREAD, 32'h30, '0);
    rd_check(32'h30, mw(32'h30), 1'b0);
  endtask
  task automatic sc_flush();
    swc_op_e fl[2] = '{SWC_OP_FLUSH, SWC_OP_EXCHANGE};
    foreach (fl[i])
    begin
      rd_check(32'h40 + i, mw(32'h40 + i), 1'b0);
      rd_check(32'h40 + i, mw(32'h40 + i), 1'b1);
      stall = fl[i] == SWC_OP_FLUSH;
      issue(fl[i], 32'h40 + i, '0);
      stall = 1'b0;
      rd_check(32'h40 + i, mw(32'h40 + i), 1'b0);
    end
  endtask
  task automatic sc_ivrc();
    rd_check(32'h60, mw(32'h60), 1'b0);
    for (int k = 0; k < 2; k++)
    begin
      inv_num = (k == 0) ? 5'h04 : 5'h03;
      inv = 1'b1;
      step();
      inv = 1'b0;
      rd_check(32'h60, mw(32'h60), k == 0);
    end
    iss = 1'b1;
    mon = 1'b1;
    step();
    chk(bo, 1'b1);
    chk(bn, 5'h09);
    mon = 1'b0;
    step();
    iss = 1'b0;
    chk(bo, 1'b0);
  endtask
  initial
  begin
    repeat (2) @(posedge clk);
    #1;
    rst_n = 1'b1;
    sc_basic();
    sc_lru();
    sc_pending();
    sc_bypass();
    sc_flush();
    sc_ivrc();
    final_report();
  end
endmodule // swc_cache_tb_top
`default_nettype wire
